// >>> src/rrex_pkg.sv
// package for the return and rotate execution block
package rrex_pkg;
  // opcode fields
  localparam logic [14:0] RRX_RET_OPC = 15'h0009;   // 0000 0000 0001 001 (s dropped)
  localparam logic [5:0] RRX_RLC_OPC = 6'h0D;       // 0011 01
  localparam int RRX_OPC_W = 16;
  localparam int RRX_PC_W = 21;
  localparam int RRX_STK_DEPTH = 31;
  localparam int RRX_SP_W = 5;
  localparam int BIT_S = 0;
  localparam int BIT_A = 8;
  localparam int BIT_D = 9;
  localparam logic [7:0] RRX_IDX_MAX = 8'h5F;       // 95
  localparam logic [7:0] RRX_BYTE_RST = 8'h00;
  localparam logic [RRX_PC_W-1:0] RRX_PC_RST = 21'h00_0000;
  localparam logic [RRX_SP_W-1:0] RRX_SP_RST = 5'h00;
  localparam logic [1:0] RRX_Q4 = 2'h3;
  // flag bit positions in the flag register
  localparam int FLG_C = 0;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 4;
  typedef enum logic [1:0] {
    RRX_IDLE = 2'b00,
    RRX_NOP = 2'b01
  } rrex_state_t;
endpackage : rrex_pkg

// >>> src/rrex_stack_mem.sv
// return stack storage with registered read
`timescale 1ns/1ps
`default_nettype none
module rrex_stack_mem
  import rrex_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [RRX_SP_W-1:0] waddr_i,
  input wire logic [RRX_PC_W-1:0] wdata_i,
  input wire logic [RRX_SP_W-1:0] raddr_i,
  output logic [RRX_PC_W-1:0] rdata_o
);
  logic [RRX_PC_W-1:0] mem [0:RRX_STK_DEPTH];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : rrex_stack_mem
`default_nettype wire

// >>> src/rrex_exec.sv
// execution of subroutine return and rotate left through carry
// Operation
// - return pops the stack and loads top_of_stack into the program counter
// - return with s=1 restores accumulator, flags, bank select from shadows
// - return with s=0 leaves accumulator, flags and bank select alone
// - return is one word, two cycles, second a nop; no flags or latches change except by the s=1 shadow restore
// - rotate shifts file register left, bit 7 to carry, carry to bit 0
// - rotate result goes to accumulator if d=0, back to file if d=1
// - indexed literal offset when a=0, extended set on and address at most 5Fh
`timescale 1ns/1ps
`default_nettype none
module rrex_exec
  import rrex_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // instruction issue, sampled at Q4 of each instruction cycle
  input wire logic [1:0] QPHASE_I,
  input wire logic ISSUE_I,
  input wire logic [RRX_OPC_W-1:0] OPCODE_I,
  input wire logic EXT_SET_EN_I,
  // stack push from the call logic
  input wire logic PUSH_I,
  input wire logic [RRX_PC_W-1:0] PUSH_DATA_I,
  // file register read data for the addressed byte
  input wire logic [7:0] FILE_RDATA_I,
  // shadow copies
  input wire logic [7:0] SHADOW_ACCUMULATOR_I,
  input wire logic [7:0] SHADOW_FLAGS_I,
  input wire logic [7:0] SHADOW_BANK_SELECT_I,
  // core state
  output logic [RRX_PC_W-1:0] PC_O,
  output logic [7:0] ACCUM_O,
  output logic [7:0] FLAGS_O,
  output logic [7:0] BANK_SELECT_REGISTER_O,
  output logic [RRX_SP_W-1:0] STK_PTR_O,
  // file register write port
  output logic FILE_WE_O,
  output logic [7:0] FILE_WDATA_O,
  output logic [7:0] FILE_ADDR_O,
  output logic FILE_INDEXED_O,
  output logic FILE_BANKED_O,
  output logic BUSY_O
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic is_ret(input logic [RRX_OPC_W-1:0] op);
    return op[RRX_OPC_W-1:1] == RRX_RET_OPC;
  endfunction : is_ret
  function automatic logic is_rlc(input logic [RRX_OPC_W-1:0] op);
    return op[RRX_OPC_W-1:10] == RRX_RLC_OPC;
  endfunction : is_rlc

  logic q4_edge;
  assign q4_edge = ISSUE_I && (QPHASE_I == RRX_Q4);

  rrex_state_t state_r, state_nxt;
  logic [RRX_PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] acc_r, acc_nxt, flg_r, flg_nxt, bsr_r, bsr_nxt;
  logic [RRX_SP_W-1:0] sp_r, sp_nxt;
  logic fwe_r, fwe_nxt, fidx_r, fidx_nxt, fbank_r, fbank_nxt;
  logic [7:0] fwd_r, fwd_nxt, fad_r, fad_nxt;
  logic [RRX_PC_W-1:0] top_of_stack;
  logic [7:0] rot;
  logic busy_r, busy_nxt;
  logic push_go;

  // a push shares the q4 slot; a return or rotate in that slot wins and the push is lost
  assign push_go = q4_edge && PUSH_I && (state_r == RRX_IDLE)
                   && !is_ret(OPCODE_I) && !is_rlc(OPCODE_I);

  // stack read port tracks the current top, so tos is valid at the pop
  rrex_stack_mem u_rrex_stack_mem (
    .clk_i(CLK_I),
    .we_i(push_go),
    .waddr_i(RRX_SP_W'(sp_r + 1'b1)),
    .wdata_i(PUSH_DATA_I),
    .raddr_i(sp_r),
    .rdata_o(top_of_stack)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    flg_nxt = flg_r;
    bsr_nxt = bsr_r;
    sp_nxt = sp_r;
    fwe_nxt = 1'b0;
    fwd_nxt = fwd_r;
    fad_nxt = fad_r;
    fidx_nxt = fidx_r;
    fbank_nxt = fbank_r;
    rot = {FILE_RDATA_I[6:0], flg_r[FLG_C]};
    case (state_r)
      RRX_IDLE: begin
        if (q4_edge && is_ret(OPCODE_I)) begin
          pc_nxt = top_of_stack;
          sp_nxt = RRX_SP_W'(sp_r - 1'b1);
          state_nxt = RRX_NOP;
          // s=0 falls through and keeps the defaults
          if (OPCODE_I[BIT_S]) begin
            acc_nxt = SHADOW_ACCUMULATOR_I;
            flg_nxt = SHADOW_FLAGS_I;
            bsr_nxt = SHADOW_BANK_SELECT_I;
          end
        end else if (q4_edge && is_rlc(OPCODE_I)) begin
          fad_nxt = OPCODE_I[7:0];
          fidx_nxt = !OPCODE_I[BIT_A] && EXT_SET_EN_I
                     && (OPCODE_I[7:0] <= RRX_IDX_MAX);
          fbank_nxt = OPCODE_I[BIT_A];
          flg_nxt[FLG_C] = FILE_RDATA_I[7];
          flg_nxt[FLG_N] = rot[7];
          flg_nxt[FLG_Z] = (rot == RRX_BYTE_RST);
          if (OPCODE_I[BIT_D]) begin
            fwe_nxt = 1'b1;
            fwd_nxt = rot;
          end else begin
            acc_nxt = rot;
          end
        end else if (push_go) begin
          sp_nxt = RRX_SP_W'(sp_r + 1'b1);
        end
      end
      RRX_NOP: begin
        // forced nop cycle: nothing but the phase moves
        if (q4_edge) begin
          state_nxt = RRX_IDLE;
        end
      end
      default: state_nxt = RRX_IDLE;
    endcase
    // busy is registered so the output leaves a flop, not a state decode
    busy_nxt = (state_nxt == RRX_NOP);
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= RRX_IDLE;
      pc_r <= RRX_PC_RST;
      acc_r <= RRX_BYTE_RST;
      flg_r <= RRX_BYTE_RST;
      bsr_r <= RRX_BYTE_RST;
      sp_r <= RRX_SP_RST;
      fwe_r <= 1'b0;
      fwd_r <= RRX_BYTE_RST;
      fad_r <= RRX_BYTE_RST;
      fidx_r <= 1'b0;
      fbank_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      flg_r <= flg_nxt;
      bsr_r <= bsr_nxt;
      sp_r <= sp_nxt;
      fwe_r <= fwe_nxt;
      fwd_r <= fwd_nxt;
      fad_r <= fad_nxt;
      fidx_r <= fidx_nxt;
      fbank_r <= fbank_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign PC_O = pc_r;
  assign ACCUM_O = acc_r;
  assign FLAGS_O = flg_r;
  assign BANK_SELECT_REGISTER_O = bsr_r;
  assign STK_PTR_O = sp_r;
  assign FILE_WE_O = fwe_r;
  assign FILE_WDATA_O = fwd_r;
  assign FILE_ADDR_O = fad_r;
  assign FILE_INDEXED_O = fidx_r;
  assign FILE_BANKED_O = fbank_r;
  assign BUSY_O = busy_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ret_pc_load: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_ret(OPCODE_I)
    |=> pc_r == $past(top_of_stack) && sp_r == $past(sp_r) - 1'b1)
    else $error("return did not load pc from stack");
  a_ret_shadow: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_ret(OPCODE_I) && OPCODE_I[BIT_S]
    |=> acc_r == $past(SHADOW_ACCUMULATOR_I) && bsr_r == $past(SHADOW_BANK_SELECT_I)
    && flg_r == $past(SHADOW_FLAGS_I))
    else $error("shadow restore missing");
  a_ret_keep: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_ret(OPCODE_I) && !OPCODE_I[BIT_S]
    |=> $stable(acc_r) && $stable(flg_r) && $stable(bsr_r))
    else $error("return without s changed state");
  a_ret_nop: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_NOP && !RST_I |-> ##1 ($stable(pc_r) && $stable(acc_r)
    && $stable(flg_r) && $stable(sp_r) && !fwe_r))
    else $error("nop cycle changed state");
  a_rot_data: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_rlc(OPCODE_I)
    |=> flg_r[FLG_C] == $past(FILE_RDATA_I[7])
    && (fwe_r ? fwd_r : acc_r) == {$past(FILE_RDATA_I[6:0]), $past(flg_r[FLG_C])})
    else $error("rotate carry wrong");
  a_rot_dest: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_rlc(OPCODE_I) && !OPCODE_I[BIT_D]
    |=> !fwe_r && acc_r == {$past(FILE_RDATA_I[6:0]), $past(flg_r[FLG_C])})
    else $error("rotate to accumulator wrong");
  a_rot_index: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_rlc(OPCODE_I)
    |=> fidx_r == ($past(!OPCODE_I[BIT_A] && EXT_SET_EN_I) && fad_r <= RRX_IDX_MAX))
    else $error("indexed mode decision wrong");
  a_rot_flags: assert property (@(posedge CLK_I) disable iff (RST_I)
    state_r == RRX_IDLE && q4_edge && is_rlc(OPCODE_I) && OPCODE_I[BIT_D]
    |=> fwe_r && flg_r[FLG_N] == fwd_r[7] && flg_r[FLG_Z] == (fwd_r == RRX_BYTE_RST)
    ##1 !fwe_r)
    else $error("rotate flags wrong");
  a_push_ptr: assert property (@(posedge CLK_I) disable iff (RST_I)
    push_go |=> sp_r == $past(sp_r) + 1'b1)
    else $error("push did not advance stack pointer");
endmodule : rrex_exec
`default_nettype wire

// >>> tb/rrex_exec_test.sv
// self-checking bench for the return and rotate execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module rrex_exec_test
  import rrex_pkg::*;
;
  typedef struct packed {
    logic [15:0] op;
    logic [7:0] fd;
    logic ext;
    logic [7:0] res;
    logic [7:0] flg;
    logic idx;
  } rrex_row_t;
  // carry chains from row to row, so the order matters
  rrex_row_t rows [4] = '{'{16'h365F, 8'h80, 1'h1, 8'h00, 8'h05, 1'h1},
    '{16'h3460, 8'h40, 1'h1, 8'h81, 8'h10, 1'h0}, '{16'h3710, 8'h55, 1'h1, 8'hAA, 8'h10, 1'h0},
    '{16'h3400, 8'hFF, 1'h0, 8'hFE, 8'h11, 1'h0}};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] qphase = 2'h0;
  logic issue_v = 1'h0;
  logic [15:0] opcode = 16'h0000;
  logic ext_en = 1'h0;
  logic push = 1'h0;
  logic [RRX_PC_W-1:0] push_data = 21'h0_0000;
  logic [7:0] file_rdata = 8'h00;
  logic [7:0] sh_acc = 8'hA5;
  logic [7:0] sh_flg = 8'h1F;
  logic [7:0] sh_bsr = 8'h0C;
  logic [RRX_PC_W-1:0] pc;
  logic [7:0] acc, flg, bank_select_register, fwd, fad, exp_acc;
  logic [RRX_SP_W-1:0] sp;
  logic fwe, fidx, fbank, busy;
  int error_cnt = 0;
  int checks = 0;
  rrex_exec u_rrex_exec (.CLK_I(clk), .RST_I(rst), .QPHASE_I(qphase), .ISSUE_I(issue_v),
    .OPCODE_I(opcode), .EXT_SET_EN_I(ext_en), .PUSH_I(push), .PUSH_DATA_I(push_data),
    .FILE_RDATA_I(file_rdata), .SHADOW_ACCUMULATOR_I(sh_acc), .SHADOW_FLAGS_I(sh_flg),
    .SHADOW_BANK_SELECT_I(sh_bsr), .PC_O(pc), .ACCUM_O(acc), .FLAGS_O(flg),
    .BANK_SELECT_REGISTER_O(bank_select_register), .STK_PTR_O(sp), .FILE_WE_O(fwe), .FILE_WDATA_O(fwd),
    .FILE_ADDR_O(fad), .FILE_INDEXED_O(fidx), .FILE_BANKED_O(fbank), .BUSY_O(busy));
  always #5 clk = ~clk;
  always @(posedge clk) qphase <= qphase + 2'h1;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // presents one request for the next q4 edge, looks at the negedge half a cycle after it
  task automatic run_op(input logic [15:0] op, input logic [7:0] fd, input logic ex,
                        input logic pu, input logic [RRX_PC_W-1:0] pd);
    do @(negedge clk); while (qphase !== 2'h2);
    @(posedge clk);
    issue_v <= 1'h1;
    opcode <= op;
    file_rdata <= fd;
    ext_en <= ex;
    push <= pu;
    push_data <= pd;
    @(posedge clk);
    issue_v <= 1'h0;
    push <= 1'h0;
    @(negedge clk);
  endtask : run_op
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
  initial begin
    exp_acc = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    `CHK("reset state", 1'h0, |{pc, acc, flg, bank_select_register, sp, fwe, busy})
    $display("reset release done");
    for (int i = 0; i < 4; i++) begin
      run_op(rows[i].op, rows[i].fd, rows[i].ext, 1'h0, 21'h0_0000);
      if (rows[i].op[9]) begin
        `CHK("file we", 1'h1, fwe)
        `CHK("file data", rows[i].res, fwd)
        `CHK("file addr", rows[i].op[7:0], fad)
      end else begin
        exp_acc = rows[i].res;
        `CHK("file we", 1'h0, fwe)
      end
      `CHK("accum", exp_acc, acc)
      `CHK("flags", rows[i].flg, flg)
      `CHK("indexed", rows[i].idx, fidx)
      `CHK("banked", rows[i].op[8], fbank)
      @(negedge clk);
      `CHK("we pulse", 1'h0, fwe)
      $display("rotate row %0d done", i);
    end
    run_op(16'h0000, 8'h00, 1'h0, 1'h1, 21'h1_2345);
    run_op(16'h0000, 8'h00, 1'h0, 1'h1, 21'h0_0ABC);
    `CHK("sp pushed", 5'h02, sp)
    run_op(16'h0012, 8'h00, 1'h0, 1'h0, 21'h0_0000);
    `CHK("pc", 21'h0_0ABC, pc)
    `CHK("sp popped", 5'h01, sp)
    `CHK("busy", 1'h1, busy)
    `CHK("kept", 24'hFE_1100, {acc, flg, bank_select_register})
    // lands on the forced nop, so it must leave no trace
    run_op(16'h3400, 8'h01, 1'h0, 1'h0, 21'h0_0000);
    `CHK("refused", 24'hFE_1100, {acc, flg, bank_select_register})
    `CHK("busy end", 1'h0, busy)
    // new shadow values, so the restore must take what stands at the return
    @(posedge clk);
    sh_acc <= 8'h5A;
    sh_flg <= 8'hE1;
    sh_bsr <= 8'h03;
    run_op(16'h0013, 8'h00, 1'h0, 1'h0, 21'h0_0000);
    `CHK("pc", 21'h1_2345, pc)
    `CHK("shadow", 24'h5A_E103, {acc, flg, bank_select_register})
    `CHK("sp empty", 5'h00, sp)
    $display("return tests done");
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    `CHK("mid reset", 1'h0, |{pc, acc, flg, bank_select_register, sp, fwe, busy})
    $display("reset test done");
    conclude();
  end
endmodule : rrex_exec_test
`default_nettype wire
